// [rtl/pca_wdt.sv]
// Purpose: counter array with PWM modules and module-4 watchdog
// Assumes: single-cycle register writes, reads answered one cycle later
// Notes: capture, high-speed and frequency output modes are not built
// Behaviour
// (RULE1) 8-bit PWM: high byte 0 gives full duty, 0xFF least, off is low
// (RULE2) 16-bit PWM: pin high on compare match, low on counter overflow
// (RULE3) 16-bit PWM only with compare, PWM and wide select all set
// (RULE4) 16-bit PWM with match enable sets event flag at each match
// (RULE5) compare low write clears compare enable, high write sets it
// (RULE6) software writes low byte first and times updates to match interrupts
// (RULE7) 16-bit PWM: compare 0 full duty, 0xFFFF least, off gives low
// (RULE8) watchdog uses module 4: high byte compared, low byte is offset
// (RULE9) watchdog comes out of every reset enabled
// (RULE10) watchdog on: counter forced, counter writes, select, idle, mode 4 frozen
// (RULE11) watchdog on: run bit writes do not stop counter, bit reads software value
// (RULE12) watchdog reset when low byte overflows with high byte matching
// (RULE13) high byte write of module 4 reloads counter high plus offset
// (RULE14) timeout is 256 times offset plus 256 minus low byte
// (RULE15) writing 1 to module 4 flag forces watchdog reset
// (RULE16) enable or lock enables watchdog; lock holds until reset
// (RULE17) software follows the documented watchdog setup order
// (RULE18) reset gives divide by 12 timebase, low byte and offset zero
// (RULE19) overflow flag set on 16-bit wrap, only software clears it
// (RULE20) run bit stops or runs counter except under watchdog
// (RULE21) module event flags set by hardware, cleared only by software
// (RULE22) control bit 5 reads zero, writes ignored
// (RULE23) three-bit select picks timebase, codes 11x give none
// (RULE24) watchdog enable set freezes other mode register bits
// (RULE25) reset request is a pulse in the cycle of detection
`timescale 1ns/1ps
`include "pca_defines.svh"

module pca_wdt (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // timebase sources and power state
  input wire logic timer0_ovf,
  input wire logic external_count_input,
  input wire logic ext_clk,
  input wire logic cpu_idle,
  // outputs to pins, interrupt and reset controllers
  output pca_pkg::pca_pins_t module_output_pin,
  output logic array_irq,
  output logic wdt_reset_req
);
  import pca_pkg::*;

  // =====================================================================
  // state
  pca_ctl_t ctl_q, ctl_d;
  pca_md_t md_q, md_d;
  pca_cpm_t cpm_q [`PCA_NMOD];
  pca_cpm_t cpm_d [`PCA_NMOD];
  logic [7:0] cpl_q [`PCA_NMOD];
  logic [7:0] cpl_d [`PCA_NMOD];
  logic [7:0] cph_q [`PCA_NMOD];
  logic [7:0] cph_d [`PCA_NMOD];
  logic [7:0] cnt_l_q, cnt_l_d, cnt_h_q, cnt_h_d;
  pca_pins_t pin_q, pin_d;
  logic [7:0] rdata_q, rdata_d;

  // =====================================================================
  // shared terms
  logic tick, wdt_en, run, lo_ovf, ovf16, wr_cn, wr_md;
  logic [15:0] cnt_nx;
  pca_ctl_t wctl;
  pca_md_t wmd;
  pca_pins_t flag_set;

  // address decode of an indexed register bank
  function automatic logic at_idx(input logic [7:0] a, input logic [7:0] base,
                                  input int i);
    return a == (base + 8'(i));
  endfunction : at_idx

  pca_tick u_tick (
    .clk(clk),
    .rst(rst),
    .counter_clock_select(md_q.counter_clock_select),
    .timer0_ovf(timer0_ovf),
    .external_count_input(external_count_input),
    .ext_clk(ext_clk),
    .tick(tick)
  );

  // (RULE16) enable or lock turns the watchdog on
  assign wdt_en = md_q.watchdog_enable | md_q.watchdog_lock;
  // (RULE20) run bit gates counting, watchdog forces it
  assign run = tick & (ctl_q.counter_run | wdt_en) & ~(md_q.idle_suspend & cpu_idle);
  assign cnt_nx = {cnt_h_q, cnt_l_q} + `PCA_WORD_ONE;
  assign lo_ovf = run & (cnt_l_q == `PCA_BYTE_MAX);
  assign ovf16 = run & ({cnt_h_q, cnt_l_q} == `PCA_WORD_MAX);
  assign wr_cn = sfr_wr & (sfr_addr == `PCA_A_CN);
  assign wr_md = sfr_wr & (sfr_addr == `PCA_A_MD);
  assign wctl = pca_ctl_t'(sfr_wdata);
  assign wmd = pca_md_t'(sfr_wdata);

  // =====================================================================
  // next-state logic for counter, modules and control registers
  always_comb begin
    pca_cpm_t m;
    logic pwm8, pwm16, hit, m8, m16;
    logic [7:0] cmp8;
    m = '0;
    pwm8 = 1'b0;
    pwm16 = 1'b0;
    hit = 1'b0;
    m8 = 1'b0;
    m16 = 1'b0;
    cmp8 = `PCA_BYTE_ZERO;
    flag_set = '0;
    pin_d = pin_q;
    // counter advances on each enabled tick
    cnt_l_d = run ? cnt_nx[7:0] : cnt_l_q;
    cnt_h_d = run ? cnt_nx[15:8] : cnt_h_q;
    // (RULE10) counter bytes not writable under watchdog
    if (sfr_wr && !wdt_en && sfr_addr == `PCA_A_CNTL) begin
      cnt_l_d = sfr_wdata;
    end
    if (sfr_wr && !wdt_en && sfr_addr == `PCA_A_CNTH) begin
      cnt_h_d = sfr_wdata;
    end
    for (int i = 0; i < `PCA_NMOD; i++) begin
      cpm_d[i] = cpm_q[i];
      cpl_d[i] = cpl_q[i];
      cph_d[i] = cph_q[i];
      m = cpm_q[i];
      // (RULE8) module 4 serves as the watchdog
      // (RULE10) module 4 forced to software timer under watchdog
      if (i == `PCA_WDM && wdt_en) begin
        m.pwm_enable = 1'b0;
        m.wide_pwm_select = 1'b0;
      end
      // (RULE3) PWM width chosen by the mode bits
      pwm8 = m.compare_enable & m.pwm_enable & ~m.wide_pwm_select;
      pwm16 = m.compare_enable & m.pwm_enable & m.wide_pwm_select;
      // at low overflow the reloaded byte is the one compared
      cmp8 = lo_ovf ? cph_q[i] : cpl_q[i];
      m8 = run & (cnt_nx[7:0] == cmp8);
      m16 = run & (cnt_nx == {cph_q[i], cpl_q[i]});
      hit = pwm8 ? m8 : m16;
      // (RULE1) (RULE7) compare off holds the pin low
      if (!(m.compare_enable && m.pwm_enable)) begin
        pin_d[i] = 1'b0;
      // (RULE2) set on match wins over clear at overflow
      end else if (hit) begin
        pin_d[i] = 1'b1;
      end else if (pwm8 ? lo_ovf : ovf16) begin
        pin_d[i] = 1'b0;
      end
      // 8-bit duty reloads from the high byte at low overflow
      if (pwm8 && lo_ovf) begin
        cpl_d[i] = cph_q[i];
      end
      // (RULE4) (RULE21) match raises the module event flag
      flag_set[i] = m.compare_enable & m.match_flag_enable & hit;
      // (RULE10) module 4 mode writes blocked under watchdog
      if (sfr_wr && at_idx(sfr_addr, `PCA_A_CPM0, i)
          && !(i == `PCA_WDM && wdt_en)) begin
        cpm_d[i] = pca_cpm_t'(sfr_wdata);
      end
      // (RULE5) low byte write clears compare enable
      if (sfr_wr && at_idx(sfr_addr, `PCA_A_CPL0, i)) begin
        cpl_d[i] = sfr_wdata;
        if (!(i == `PCA_WDM && wdt_en)) begin
          cpm_d[i].compare_enable = 1'b0;
        end
      end
      if (sfr_wr && at_idx(sfr_addr, `PCA_A_CPH0, i)) begin
        // (RULE13) (RULE14) refresh loads counter high plus offset
        // the written value is dropped, so any byte refreshes the watchdog
        if (i == `PCA_WDM && wdt_en) begin
          cph_d[i] = cnt_h_q + cpl_q[i];
        // (RULE5) high byte write sets compare enable
        end else begin
          cph_d[i] = sfr_wdata;
          cpm_d[i].compare_enable = 1'b1;
        end
      end
    end
    // (RULE19) (RULE21) hardware set wins over a software clear
    ctl_d = ctl_q;
    if (wr_cn) begin
      ctl_d = wctl;
    end
    ctl_d.counter_overflow_flag = ctl_d.counter_overflow_flag | ovf16;
    ctl_d.module_event_flag = ctl_d.module_event_flag | flag_set;
    // (RULE22) unused bit never stores
    ctl_d.cn_unused = 1'b0;
    // (RULE24) only the enable bit moves while the watchdog is on
    md_d = md_q;
    if (wr_md) begin
      if (wdt_en) begin
        md_d.watchdog_enable = wmd.watchdog_enable;
      end else begin
        md_d = wmd;
        md_d.md_unused = 1'b0;
      end
      // (RULE16) lock is sticky until reset
      md_d.watchdog_lock = md_q.watchdog_lock | md_d.watchdog_lock;
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      // (RULE9) (RULE18) watchdog on, div-12 timebase, bytes zero
      ctl_q <= pca_ctl_t'(`PCA_CN_RST);
      md_q <= pca_md_t'(`PCA_MD_RST);
      cnt_l_q <= `PCA_BYTE_ZERO;
      cnt_h_q <= `PCA_BYTE_ZERO;
      pin_q <= '0;
      for (int i = 0; i < `PCA_NMOD; i++) begin
        cpm_q[i] <= '0;
        cpl_q[i] <= `PCA_BYTE_ZERO;
        cph_q[i] <= `PCA_BYTE_ZERO;
      end
    end else begin
      ctl_q <= ctl_d;
      md_q <= md_d;
      cnt_l_q <= cnt_l_d;
      cnt_h_q <= cnt_h_d;
      pin_q <= pin_d;
      for (int i = 0; i < `PCA_NMOD; i++) begin
        cpm_q[i] <= cpm_d[i];
        cpl_q[i] <= cpl_d[i];
        cph_q[i] <= cph_d[i];
      end
    end
  end

  // =====================================================================
  // read port: data returned the cycle after the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd) begin
      rdata_d = `PCA_BYTE_ZERO;
      case (sfr_addr)
        // (RULE11) run bit shows only what software wrote
        `PCA_A_CN: rdata_d = ctl_q;
        `PCA_A_MD: rdata_d = md_q;
        `PCA_A_CNTL: rdata_d = cnt_l_q;
        `PCA_A_CNTH: rdata_d = cnt_h_q;
        default: rdata_d = `PCA_BYTE_ZERO;
      endcase
      for (int i = 0; i < `PCA_NMOD; i++) begin
        if (at_idx(sfr_addr, `PCA_A_CPM0, i)) begin
          rdata_d = cpm_q[i];
        end
        if (at_idx(sfr_addr, `PCA_A_CPL0, i)) begin
          rdata_d = cpl_q[i];
        end
        if (at_idx(sfr_addr, `PCA_A_CPH0, i)) begin
          rdata_d = cph_q[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= `PCA_BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // =====================================================================
  // outputs
  assign sfr_rdata = rdata_q;
  assign module_output_pin = pin_q;
  // (RULE19) (RULE21) array interrupt from enabled flags
  always_comb begin
    array_irq = ctl_q.counter_overflow_flag & md_q.overflow_irq_enable;
    for (int i = 0; i < `PCA_NMOD; i++) begin
      array_irq = array_irq | (ctl_q.module_event_flag[i] & cpm_q[i].module_irq_enable);
    end
  end
  // (RULE12) (RULE15) (RULE25) expiry or forced reset, same cycle
  assign wdt_reset_req = wdt_en & ((lo_ovf & (cnt_h_q == cph_q[`PCA_WDM]))
                                   | (wr_cn & wctl.module_event_flag[`PCA_WDM]));

  // =====================================================================
  // assertions
  a_ecom_clear: assert property (@(posedge clk) disable iff (rst) // (RULE5)
    sfr_wr && sfr_addr == `PCA_A_CPL0 |=> !cpm_q[0].compare_enable)
    else $error("compare enable not cleared by low byte write");
  a_ecom_set: assert property (@(posedge clk) disable iff (rst) // (RULE5)
    sfr_wr && sfr_addr == `PCA_A_CPH0 |=> cpm_q[0].compare_enable)
    else $error("compare enable not set by high byte write");
  a_pwm_off_low: assert property (@(posedge clk) disable iff (rst) // (RULE7)
    !cpm_q[0].compare_enable |=> !module_output_pin[0])
    else $error("pin not low with compare disabled");
  a_pwm16_rise: assert property (@(posedge clk) disable iff (rst) // (RULE2)
    cpm_q[0].compare_enable && cpm_q[0].pwm_enable && cpm_q[0].wide_pwm_select
    && run && cnt_nx == {cph_q[0], cpl_q[0]} && !sfr_wr |=> module_output_pin[0])
    else $error("16-bit PWM pin not set at match");
  a_wdt_expire: assert property (@(posedge clk) disable iff (rst) // (RULE12)
    wdt_en && lo_ovf && cnt_h_q == cph_q[`PCA_WDM] |-> wdt_reset_req)
    else $error("watchdog expiry gave no reset");
  a_wdt_force: assert property (@(posedge clk) disable iff (rst) // (RULE15)
    wdt_en && wr_cn && sfr_wdata[`PCA_WDM] |-> wdt_reset_req)
    else $error("forced watchdog reset missing");
  a_wdt_refresh: assert property (@(posedge clk) disable iff (rst) // (RULE13)
    wdt_en && sfr_wr && at_idx(sfr_addr, `PCA_A_CPH0, `PCA_WDM)
    |=> cph_q[`PCA_WDM] == 8'($past(cnt_h_q) + $past(cpl_q[`PCA_WDM])))
    else $error("watchdog refresh loaded wrong value");
  a_cnt_frozen: assert property (@(posedge clk) disable iff (rst) // (RULE10)
    wdt_en && sfr_wr && sfr_addr == `PCA_A_CNTL
    |=> cnt_l_q == ($past(run) ? $past(cnt_nx[7:0]) : $past(cnt_l_q)))
    else $error("counter written while watchdog on");
  a_cf_set: assert property (@(posedge clk) disable iff (rst) // (RULE19)
    ovf16 |=> ctl_q.counter_overflow_flag)
    else $error("overflow flag not set on wrap");
  a_unused_zero: assert property (@(posedge clk) disable iff (rst) // (RULE22)
    sfr_rd && sfr_addr == `PCA_A_CN |=> !sfr_rdata[5])
    else $error("unused control bit reads one");
  a_lock_hold: assert property (@(posedge clk) disable iff (rst) // (RULE16)
    md_q.watchdog_lock |=> md_q.watchdog_lock && wdt_en)
    else $error("watchdog lock released");
  a_reset_on: assert property (@(posedge clk) // (RULE9)
    rst |=> md_q.watchdog_enable && md_q.counter_clock_select == `PCA_CS_DIV12)
    else $error("watchdog not enabled after reset");
  a_cnth_frozen: assert property (@(posedge clk) disable iff (rst) // (RULE10)
    wdt_en && !lo_ovf && sfr_wr && sfr_addr == `PCA_A_CNTH |=> $stable(cnt_h_q))
    else $error("counter high written while watchdog on");
  a_flag_hold: assert property (@(posedge clk) disable iff (rst) // (RULE21)
    ctl_q.module_event_flag[0] && !wr_cn |=> ctl_q.module_event_flag[0])
    else $error("event flag cleared by hardware");
  a_md_frozen: assert property (@(posedge clk) disable iff (rst) // (RULE24)
    md_q.watchdog_enable && wr_md
    |=> $stable(md_q.counter_clock_select) && $stable(md_q.idle_suspend))
    else $error("mode bits changed while watchdog on");

endmodule : pca_wdt

// [rtl/pca_defines.svh]
// Purpose: named constants for the counter array, PWM and watchdog block
// Assumes: 8-bit special function register port, one system clock
// Notes: addresses of the counter and compare bytes are local choices
`ifndef PCA_DEFINES_SVH
`define PCA_DEFINES_SVH

// =====================================================================
// register addresses
`define PCA_A_CN 8'hD8
`define PCA_A_MD 8'hD9
`define PCA_A_CPM0 8'hDA
`define PCA_A_CNTL 8'hE9
`define PCA_A_CPL0 8'hEA
`define PCA_A_CNTH 8'hF9
`define PCA_A_CPH0 8'hFA

// =====================================================================
// sizes, reset values and limits
`define PCA_NMOD 5
`define PCA_WDM 4
`define PCA_CN_RST 8'h00
`define PCA_MD_RST 8'h40
`define PCA_BYTE_ZERO 8'h00
`define PCA_BYTE_MAX 8'hFF
`define PCA_WORD_MAX 16'hFFFF
`define PCA_WORD_ONE 16'h0001

// =====================================================================
// timebase select codes and divider figures
`define PCA_CS_DIV12 3'h0
`define PCA_CS_DIV4 3'h1
`define PCA_CS_T0 3'h2
`define PCA_CS_ECI 3'h3
`define PCA_CS_SYS 3'h4
`define PCA_CS_EXT8 3'h5
`define PCA_DIV12_LAST 4'hB
`define PCA_DIV4_LAST 2'h3
`define PCA_EXT8_LAST 3'h7

`endif

// [rtl/pca_pkg.sv]
// Purpose: shared types for the counter array block
// Assumes: constants come from pca_defines.svh
// Notes: struct field order matches the register bit order, msb first
`include "pca_defines.svh"

package pca_pkg;

  // =====================================================================
  // register layouts
  typedef struct packed {
    logic counter_overflow_flag;
    logic counter_run;
    logic cn_unused;
    logic [`PCA_NMOD-1:0] module_event_flag;
  } pca_ctl_t;

  typedef struct packed {
    logic idle_suspend;
    logic watchdog_enable;
    logic watchdog_lock;
    logic md_unused;
    logic [2:0] counter_clock_select;
    logic overflow_irq_enable;
  } pca_md_t;

  typedef struct packed {
    logic wide_pwm_select;
    logic compare_enable;
    logic capture_pos;
    logic capture_neg;
    logic match_flag_enable;
    logic toggle_enable;
    logic pwm_enable;
    logic module_irq_enable;
  } pca_cpm_t;

  typedef logic [`PCA_NMOD-1:0] pca_pins_t;

endpackage : pca_pkg

// [rtl/pca_tick.sv]
// Purpose: counter timebase, one-cycle tick per counter clock
// Assumes: all source inputs are synchronous to clk
// Notes: reserved select codes give no tick at all
`timescale 1ns/1ps
`include "pca_defines.svh"

module pca_tick (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // source choice and sources
  input wire logic [2:0] counter_clock_select,
  input wire logic timer0_ovf,
  input wire logic external_count_input,
  input wire logic ext_clk,
  // timebase strobe
  output logic tick
);
  logic [3:0] div_q, div_d;
  logic [2:0] e8_q, e8_d;
  logic eci_q, eci_d, ext_q, ext_d, tick_q, tick_d;
  logic ext_rise;

  // one free-running divider serves both /12 and /4, since 4 divides 12
  always_comb begin
    div_d = (div_q == `PCA_DIV12_LAST) ? 4'h0 : div_q + 4'h1;
    eci_d = external_count_input;
    ext_d = ext_clk;
    ext_rise = ext_clk & ~ext_q;
    e8_d = ext_rise ? e8_q + 3'h1 : e8_q;
    // (RULE23) timebase select
    case (counter_clock_select)
      `PCA_CS_DIV12: tick_d = (div_q == `PCA_DIV12_LAST);
      `PCA_CS_DIV4: tick_d = (div_q[1:0] == `PCA_DIV4_LAST);
      `PCA_CS_T0: tick_d = timer0_ovf;
      `PCA_CS_ECI: tick_d = eci_q & ~external_count_input;
      `PCA_CS_SYS: tick_d = 1'b1;
      `PCA_CS_EXT8: tick_d = ext_rise & (e8_q == `PCA_EXT8_LAST);
      default: tick_d = 1'b0;
    endcase
  end

  // registered strobe keeps the counter path short
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 4'h0;
      e8_q <= 3'h0;
      eci_q <= 1'b0;
      ext_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      e8_q <= e8_d;
      eci_q <= eci_d;
      ext_q <= ext_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : pca_tick

// [testbench/tb.sv]
// Purpose: self-checking bench for the counter array, PWM and watchdog block
// Assumes: register port answers a read one cycle after it is taken
// Notes: only the system clock timebases are exercised; other sources idle
`timescale 1ns/1ps

module tb;
  import pca_pkg::*;

  // =====================================================================
  // signals and counters
  typedef struct {
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] exp;
  } pca_tb_row_t;
  localparam int CEIL = 20000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic timer0_ovf = 1'b0;
  logic external_count_input = 1'b0;
  logic ext_clk = 1'b0;
  logic cpu_idle = 1'b0;
  pca_pins_t module_output_pin;
  logic array_irq;
  logic wdt_reset_req;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  int t0;
  logic [7:0] got;
  logic seen;
  // write, then read back; mode first so the watchdog stops early
  pca_tb_row_t rows [13] = '{
    '{8'hD9, 8'h08, 8'hD9, 8'h00}, '{8'hD9, 8'h9F, 8'hD9, 8'h8F},
    '{8'hD9, 8'h08, 8'hD9, 8'h08}, '{8'hD8, 8'h20, 8'hD8, 8'h00},
    '{8'hDA, 8'hC2, 8'hDA, 8'hC2}, '{8'hDA, 8'h42, 8'hDA, 8'h42},
    '{8'hEA, 8'h12, 8'hDA, 8'h02}, '{8'hFA, 8'h80, 8'hDA, 8'h42},
    '{8'hEA, 8'h34, 8'hEA, 8'h34}, '{8'hE9, 8'h34, 8'hE9, 8'h34},
    '{8'h80, 8'h55, 8'h80, 8'h00}, '{8'hDB, 8'h3C, 8'hDB, 8'h3C},
    '{8'hEE, 8'h11, 8'hEE, 8'h11}};

  pca_wdt dut_u (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer0_ovf(timer0_ovf),
    .external_count_input(external_count_input), .ext_clk(ext_clk),
    .cpu_idle(cpu_idle), .module_output_pin(module_output_pin),
    .array_irq(array_irq), .wdt_reset_req(wdt_reset_req));

  // =====================================================================
  // clock and hang guard
  always #10 clk = ~clk;

  // the ceiling is several times the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc >= CEIL) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end

  // =====================================================================
  // tasks
  task automatic give_verdict;
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic check_byte(input logic [7:0] g, input logic [7:0] e, input string w);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %h want %h", $time, w, g, e);
    end
  endtask : check_byte

  task automatic check_bit(input logic g, input logic e, input string w);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t %s got %b want %b", $time, w, g, e);
    end
  endtask : check_bit

  task automatic check_num(input int g, input int lo, input int hi, input string w);
    n_checks++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("[ERR] %0t %s got %0d want %0d..%0d", $time, w, g, lo, hi);
    end
  endtask : check_num

  // strobe held across exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    check_byte(sfr_rdata, e, w);
  endtask : rd

  task automatic wait_req(input int lim, output int k);
    k = 0;
    while (wdt_reset_req !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_req

  task automatic count_high(input int len, output int k);
    k = 0;
    repeat (len) begin
      @(negedge clk);
      if (module_output_pin[0] === 1'b1) k++;
    end
  endtask : count_high

  // forced-reset write; the pulse may show in the write cycle or just after
  task automatic force_try(output logic s);
    @(negedge clk);
    sfr_addr = 8'hD8;
    sfr_wdata = 8'h10;
    sfr_wr = 1'b1;
    #5 s = wdt_reset_req;
    @(negedge clk);
    sfr_wr = 1'b0;
    s = s | wdt_reset_req;
  endtask : force_try

  // =====================================================================
  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t0 = cyc;
    rd(8'hD9, 8'h40, "mode reset");
    rd(8'hD8, 8'h00, "control reset");
    rd(8'hEE, 8'h00, "offset reset");
    wait_req(4000, n);
    check_num(cyc - t0, 3060, 3090, "default timeout");
    @(negedge clk);
    check_bit(wdt_reset_req, 1'b0, "pulse width");
    // table of plain register cases
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, rows[i].exp, "row");
    end
    // 16-bit PWM, 16 ticks high before the wrap
    wr(8'hDA, 8'hCA);
    wr(8'hEA, 8'hF0);
    wr(8'hFA, 8'hFF);
    wr(8'hF9, 8'hFF);
    wr(8'hE9, 8'hE0);
    wr(8'hD8, 8'h40);
    n = 0;
    while (module_output_pin[0] !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (module_output_pin[0] === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check_num(n, 16, 16, "wide high time");
    rd(8'hD8, 8'hC1, "flags after wrap");
    check_bit(array_irq, 1'b0, "irq masked");
    wr(8'hD9, 8'h09);
    check_bit(array_irq, 1'b1, "irq enabled");
    wr(8'hD8, 8'h40);
    rd(8'hD8, 8'h40, "flags cleared");
    check_bit(array_irq, 1'b0, "irq cleared");
    // compare off holds the pin low across a match
    wr(8'hEA, 8'hF0);
    wr(8'hF9, 8'hFF);
    wr(8'hE9, 8'hE0);
    count_high(60, n);
    check_num(n, 0, 0, "wide off");
    wr(8'hDA, 8'h42);
    wr(8'hEA, 8'h00);
    wr(8'hFA, 8'h00);
    count_high(300, n);
    count_high(256, n);
    check_num(n, 256, 256, "full duty");
    wr(8'hFA, 8'hFF);
    count_high(300, n);
    count_high(512, n);
    check_num(n, 2, 2, "least duty");
    wr(8'hEA, 8'h00);
    count_high(300, n);
    check_num(n, 0, 0, "narrow off");
    wr(8'hD8, 8'h00);
    // refresh with offset 2 just after the watchdog starts a zeroed counter
    wr(8'hE9, 8'h00);
    wr(8'hF9, 8'h00);
    wr(8'hEE, 8'h02);
    wr(8'hD9, 8'h48);
    wr(8'hFE, 8'h5A);
    t0 = cyc;
    rd(8'hFE, 8'h02, "refresh value");
    wr(8'hE9, 8'h77);
    wr(8'hF9, 8'h77);
    rd(8'hF9, 8'h00, "counter frozen");
    wr(8'hD9, 8'h4A);
    rd(8'hD9, 8'h48, "mode frozen");
    rd(8'hD8, 8'h00, "run reads zero");
    wait_req(1000, n);
    check_num(cyc - t0, 760, 772, "refresh timeout");
    @(negedge clk);
    check_bit(wdt_reset_req, 1'b0, "pulse width");
    force_try(seen);
    check_bit(seen, 1'b1, "forced reset");
    wr(8'hD9, 8'h08);
    force_try(seen);
    check_bit(seen, 1'b0, "off no force");
    wr(8'hD8, 8'h00);
    wr(8'hD9, 8'h20);
    rd(8'hD9, 8'h20, "lock set");
    wr(8'hD9, 8'h08);
    rd(8'hD9, 8'h20, "lock held");
    force_try(seen);
    check_bit(seen, 1'b1, "locked force");
    // a second reset drops the lock and re-arms the watchdog
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd(8'hD9, 8'h40, "mode after reset");
    give_verdict();
  end
endmodule : tb
